/* ptmr_top.v */
// Behaviour
// - counter readable only, low byte bits 7..0, high byte bits 9..8, reset zero
// - compare a value is read/write, split low and high bytes, reset zero
// - compare b value is read/write, split low and high bytes, reset zero
// - period value is read/write, high two bits in own byte, reset zero
// - high byte bits 7..2 read as zero
// - mode field: 00 compare output, 11 timer/counter, 10 pwm
// - clear select low: clear on period match or overflow when period zero, both flags
// - clear select high: clear on compare a match, only compare a flag
// - compare a zero: count to 3FF and overflow, no compare a flag
// - in compare output mode compare a zero is no clear point
// - compare mode output changes only on compare a match or enable rising edge
// - compare a match drives output high, low, toggle or unchanged per pin field
// - enable rising edge forces output to initial level from output control
// - timer/counter mode counts like compare mode but leaves pin undriven
// - pwm mode ignores clear select, period match clears, compare a sets duty
// - pwm period equals period value, zero gives 1024 clocks
// - duty at or above period gives full-period active output
// - pwm raises compare a flag and period flag on their matches
// - pwm: output control picks active level, pin field enables, invert bit inverts
// - pwm counting keeps running while pin field forces a fixed level
// - compare mode pin field: 00 none, 01 low, 10 high, 11 toggle
// - enable rise resets counter to zero, enable fall holds its value
// - pwm pin field: 00 forced inactive, 01 forced active, 10 pwm waveform
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_map.vh"

module ptmr_top #(
    parameter CNT_W = 10
) (
    // clock and reset
    input wire CLK,
    input wire RESET_N,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // timer tick enable from the clock source, already in this domain
    input wire TICK,
    // output pin
    output wire TMR_OUT,
    output wire TMR_OUT_OE,
    // match pulses
    output reg CMPA_MATCH,
    output reg PER_MATCH
);

    // compare a value, low byte and two-bit high byte
    reg [7:0] cmpa_lo_ff;
    reg [7:0] cmpa_hi_ff;
    // compare b value, stored for software only
    reg [7:0] cmpb_lo_ff;
    reg [7:0] cmpb_hi_ff;
    // period value, low byte and two-bit high byte
    reg [7:0] per_lo_ff;
    reg [7:0] per_hi_ff;

    // control 0: enable and pause
    reg [7:0] ctrl0_ff;
    // control 1: mode, pin field, output control, invert, clear select
    reg [7:0] ctrl1_ff;

    // the running counter and its next value
    reg [CNT_W-1:0] cnt_ff;
    reg [CNT_W-1:0] nxt_cnt;

    // enable delayed one clock, for the rising edge detector
    reg en_d_ff;
    // compare-mode pin level and its next value
    reg out_ff;
    reg nxt_out;
    // pwm waveform before active level and invert
    reg pwm_out_ff;
    reg nxt_pwm_out;

    // sticky match flags, cleared by writing one
    reg flag_a_ff;
    reg flag_p_ff;

    // comparator hits in this cycle
    reg match_a;
    reg match_p;
    // counter clear request
    reg clr;
    // pwm period in clocks, one bit wider to hold 1024
    reg [CNT_W:0] period;

    // ten-bit compare values assembled from their bytes
    wire [CNT_W-1:0] cmpa_val;
    wire [CNT_W-1:0] per_val;

    // decoded control fields
    wire [1:0] mode;
    wire [1:0] pinf;
    wire enable;
    wire pause;
    wire octl;
    wire inv;
    wire clrsel;

    // enable edge and count qualifier
    wire en_rise;
    wire run;

    // bus access strobes and decode result
    wire wr_acc;
    wire rd_acc;
    reg addr_ok;

    assign cmpa_val = {cmpa_hi_ff[1:0], cmpa_lo_ff};
    assign per_val = {per_hi_ff[1:0], per_lo_ff};
    assign mode = ctrl1_ff[`PTMR_C1_MODE_HI:`PTMR_C1_MODE_LO];
    assign pinf = ctrl1_ff[`PTMR_C1_PINF_HI:`PTMR_C1_PINF_LO];
    assign octl = ctrl1_ff[`PTMR_C1_OCTL];
    assign inv = ctrl1_ff[`PTMR_C1_INV];
    assign clrsel = ctrl1_ff[`PTMR_C1_CLRSEL];
    assign enable = ctrl0_ff[`PTMR_C0_ENABLE];
    assign pause = ctrl0_ff[`PTMR_C0_PAUSE];
    assign en_rise = enable & ~en_d_ff;
    assign run = enable & ~pause & TICK;

    // apb: zero wait states, error on unmapped address
    assign PREADY = 1'b1;
    assign wr_acc = PSEL & PENABLE & PWRITE;
    assign rd_acc = PSEL & PENABLE & ~PWRITE;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    // read mux and address decode
    always @* begin
        addr_ok = 1'b1;
        PRDATA = 32'h00000000;
        case (PADDR)
            `PTMR_ADDR_CNT_LO: PRDATA = {24'h000000, cnt_ff[7:0]};
            `PTMR_ADDR_CNT_HI: PRDATA = {30'h00000000, cnt_ff[9:8]};
            `PTMR_ADDR_CMPA_LO: PRDATA = {24'h000000, cmpa_lo_ff};
            `PTMR_ADDR_CMPA_HI: PRDATA = {24'h000000, cmpa_hi_ff};
            `PTMR_ADDR_CMPB_LO: PRDATA = {24'h000000, cmpb_lo_ff};
            `PTMR_ADDR_CMPB_HI: PRDATA = {24'h000000, cmpb_hi_ff};
            `PTMR_ADDR_PER_LO: PRDATA = {24'h000000, per_lo_ff};
            `PTMR_ADDR_PER_HI: PRDATA = {24'h000000, per_hi_ff};
            `PTMR_ADDR_CTRL0: PRDATA = {24'h000000, ctrl0_ff};
            `PTMR_ADDR_CTRL1: PRDATA = {24'h000000, ctrl1_ff};
            `PTMR_ADDR_FLAGS: PRDATA = {30'h00000000, flag_p_ff, flag_a_ff};
            default: addr_ok = 1'b0;
        endcase
    end

    // register writes; high bytes keep only bits 1..0
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmpa_lo_ff <= `PTMR_RST_BYTE;
            cmpa_hi_ff <= `PTMR_RST_BYTE;
            cmpb_lo_ff <= `PTMR_RST_BYTE;
            cmpb_hi_ff <= `PTMR_RST_BYTE;
            per_lo_ff <= `PTMR_RST_BYTE;
            per_hi_ff <= `PTMR_RST_BYTE;
            ctrl0_ff <= `PTMR_RST_BYTE;
            ctrl1_ff <= `PTMR_RST_BYTE;
        end else if (wr_acc) begin
            case (PADDR)
                `PTMR_ADDR_CMPA_LO: cmpa_lo_ff <= PWDATA[7:0];
                `PTMR_ADDR_CMPA_HI: cmpa_hi_ff <= {6'h00, PWDATA[1:0]};
                `PTMR_ADDR_CMPB_LO: cmpb_lo_ff <= PWDATA[7:0];
                `PTMR_ADDR_CMPB_HI: cmpb_hi_ff <= {6'h00, PWDATA[1:0]};
                `PTMR_ADDR_PER_LO: per_lo_ff <= PWDATA[7:0];
                `PTMR_ADDR_PER_HI: per_hi_ff <= {6'h00, PWDATA[1:0]};
                `PTMR_ADDR_CTRL0: ctrl0_ff <= {PWDATA[7], 3'h0, PWDATA[3], 3'h0};
                `PTMR_ADDR_CTRL1: ctrl1_ff <= {PWDATA[7:2], 1'b0, PWDATA[0]};
                default: ctrl0_ff <= ctrl0_ff;
            endcase
        end
    end

    // comparators and counter clear choice
    always @* begin
        // compare a zero never matches, so no clear point and no flag
        match_a = run && (cmpa_val != `PTMR_RST_CNT) && (cnt_ff + 10'h001 == cmpa_val);
        // period zero: the counter wraps at 3FF, counted as the period point
        match_p = run && ((per_val == `PTMR_RST_CNT) ? (cnt_ff == `PTMR_CNT_MAX)
                  : (cnt_ff + 10'h001 == per_val));
        if (mode == `PTMR_MODE_PWM)
            clr = match_p;
        else if (clrsel)
            clr = match_a | (run && cnt_ff == `PTMR_CNT_MAX);
        else
            clr = match_p;
        if (en_rise)
            nxt_cnt = `PTMR_RST_CNT;
        else if (!run)
            nxt_cnt = cnt_ff;
        else if (clr)
            nxt_cnt = `PTMR_RST_CNT;
        else
            nxt_cnt = cnt_ff + 10'h001;
    end

    // counter, enable edge detector and match flags
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_ff <= `PTMR_RST_CNT;
            en_d_ff <= 1'b0;
            flag_a_ff <= 1'b0;
            flag_p_ff <= 1'b0;
            CMPA_MATCH <= 1'b0;
            PER_MATCH <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            en_d_ff <= enable;
            CMPA_MATCH <= match_a;
            // period flag is suppressed when compare a clears outside pwm
            PER_MATCH <= match_p & ~(clrsel & (mode != `PTMR_MODE_PWM));
            // flags: set wins over a write-one-to-clear
            flag_a_ff <= match_a | (flag_a_ff &
                ~(wr_acc && PADDR == `PTMR_ADDR_FLAGS && PWDATA[`PTMR_FL_CMPA]));
            flag_p_ff <= (match_p & ~(clrsel & (mode != `PTMR_MODE_PWM))) | (flag_p_ff &
                ~(wr_acc && PADDR == `PTMR_ADDR_FLAGS && PWDATA[`PTMR_FL_PER]));
        end
    end

    // compare-mode pin level and pwm waveform
    always @* begin
        nxt_out = out_ff;
        if (en_rise)
            nxt_out = octl;
        else if (match_a && mode == `PTMR_MODE_CMP) begin
            case (pinf)
                `PTMR_PF_LOW: nxt_out = 1'b0;
                `PTMR_PF_HIGH: nxt_out = 1'b1;
                `PTMR_PF_TOGGLE: nxt_out = ~out_ff;
                default: nxt_out = out_ff;
            endcase
        end
        // active while the next count is below duty; duty >= period stays active
        period = (per_val == `PTMR_RST_CNT) ? 11'h400 : {1'b0, per_val};
        nxt_pwm_out = ({1'b0, cmpa_val} >= period) ? 1'b1
                      : (nxt_cnt < cmpa_val);
    end

    // output flops
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_ff <= 1'b0;
            pwm_out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            pwm_out_ff <= nxt_pwm_out;
        end
    end

    // pin drive: pwm active level from output control, then invert
    reg pin_lvl;
    always @* begin
        case (mode)
            `PTMR_MODE_PWM: begin
                case (pinf)
                    `PTMR_PF_NONE: pin_lvl = ~octl;
                    `PTMR_PF_LOW: pin_lvl = octl;
                    `PTMR_PF_HIGH: pin_lvl = pwm_out_ff ? octl : ~octl;
                    default: pin_lvl = ~octl;
                endcase
            end
            `PTMR_MODE_CMP: pin_lvl = out_ff;
            default: pin_lvl = 1'b0;
        endcase
    end
    assign TMR_OUT = (mode == `PTMR_MODE_TMR) ? 1'b0 : (pin_lvl ^ inv);
    assign TMR_OUT_OE = (mode == `PTMR_MODE_CMP) || (mode == `PTMR_MODE_PWM);

endmodule
`default_nettype wire

/* ptmr_map.vh */
`ifndef PTMR_MAP_VH
`define PTMR_MAP_VH

// register byte addresses on the apb bus
`define PTMR_ADDR_CNT_LO 12'h000
`define PTMR_ADDR_CNT_HI 12'h004
`define PTMR_ADDR_CMPA_LO 12'h008
`define PTMR_ADDR_CMPA_HI 12'h00C
`define PTMR_ADDR_CMPB_LO 12'h010
`define PTMR_ADDR_CMPB_HI 12'h014
`define PTMR_ADDR_PER_LO 12'h018
`define PTMR_ADDR_PER_HI 12'h01C
`define PTMR_ADDR_CTRL0 12'h020
`define PTMR_ADDR_CTRL1 12'h024
`define PTMR_ADDR_FLAGS 12'h028

// control 0 fields
`define PTMR_C0_ENABLE 3
`define PTMR_C0_PAUSE 7
// control 1 fields
`define PTMR_C1_MODE_HI 7
`define PTMR_C1_MODE_LO 6
`define PTMR_C1_PINF_HI 5
`define PTMR_C1_PINF_LO 4
`define PTMR_C1_OCTL 3
`define PTMR_C1_INV 2
`define PTMR_C1_CLRSEL 0
// flag register fields
`define PTMR_FL_CMPA 0
`define PTMR_FL_PER 1

// mode codes
`define PTMR_MODE_CMP 2'h0
`define PTMR_MODE_PWM 2'h2
`define PTMR_MODE_TMR 2'h3

// pin function codes
`define PTMR_PF_NONE 2'h0
`define PTMR_PF_LOW 2'h1
`define PTMR_PF_HIGH 2'h2
`define PTMR_PF_TOGGLE 2'h3

// reset values and counter maximum
`define PTMR_RST_BYTE 8'h00
`define PTMR_RST_CNT 10'h000
`define PTMR_CNT_MAX 10'h3FF

`endif

/* ptmr_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ptmr_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // apb slave side
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // timer side
    input wire logic TICK,
    input wire logic TMR_OUT,
    input wire logic TMR_OUT_OE,
    input wire logic CMPA_MATCH,
    input wire logic PER_MATCH
);
    logic [7:0] c1_ff;
    logic [2:0] idle_ff;
    wire rd = PSEL && PENABLE && !PWRITE;
    wire [1:0] md = c1_ff[7:6];
    wire [1:0] pf = c1_ff[5:4];
    wire inv = c1_ff[2];
    wire q = idle_ff == 3'h7;
    // control 1 shadow and quiet cycles since the last access
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            c1_ff <= 8'h00;
            idle_ff <= 3'h0;
        end else begin
            if (PSEL && PENABLE && PWRITE && PADDR == 12'h024) c1_ff <= PWDATA[7:0];
            idle_ff <= PSEL ? 3'h0 : idle_ff + {2'h0, !q};
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // register reads and pin behaviour per mode
    property p_lo_zero; rd && PADDR < 12'h020 |-> PRDATA[31:8] == 24'h0; endproperty
    a_lo_zero: assert property (p_lo_zero) else $error("byte read wide");
    property p_hi_zero; rd && PADDR[2] && PADDR < 12'h020 |-> PRDATA[31:2] == 30'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("high byte wide");
    property p_oe; q |-> TMR_OUT_OE == !md[0]; endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_tmr_low; q && md == 2'h3 |-> !TMR_OUT; endproperty
    a_tmr_low: assert property (p_tmr_low) else $error("timer mode pin");
    property p_no_per; q && c1_ff[0] && md != 2'h2 |-> !PER_MATCH; endproperty
    a_no_per: assert property (p_no_per) else $error("period flag");
    property p_toggle; q && md == 2'h0 && pf == 2'h3 && CMPA_MATCH |-> TMR_OUT != $past(TMR_OUT);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
    property p_drive; q && md == 2'h0 && pf inside {2'h1, 2'h2} && CMPA_MATCH
        |-> TMR_OUT == (pf[1] ^ inv); endproperty
    a_drive: assert property (p_drive) else $error("match level");
    property p_per_keep; q && md == 2'h0 && PER_MATCH && !CMPA_MATCH |-> $stable(TMR_OUT);
    endproperty
    a_per_keep: assert property (p_per_keep) else $error("period moved pin");
    property p_forced; q && md == 2'h2 && !pf[1] |-> TMR_OUT == (!(c1_ff[3] ^ pf[0]) ^ inv);
    endproperty
    a_forced: assert property (p_forced) else $error("forced level");
    c_cmp: cover property (md == 2'h0 && CMPA_MATCH);
    c_pwm: cover property (md == 2'h2 && PER_MATCH);
    c_tmr: cover property (md == 2'h3 && PER_MATCH);
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, TICK = 0, sl;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, rv, s = 7;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, TMR_OUT, TMR_OUT_OE, CMPA_MATCH, PER_MATCH;
    int n_errors = 0, checks_done = 0, g, h, o, p, a;
    ptmr_top DUT (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .TICK, .TMR_OUT, .TMR_OUT_OE, .CMPA_MATCH, .PER_MATCH);
    // 40 mhz clock
    always #12.5 CLK = ~CLK;
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic chk(input logic [127:0] v, input logic [127:0] e);
        checks_done++;
        if (v !== e) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, v, e);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rv = PRDATA;
        sl = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // timer off, load compare a and period, set control 1, timer on
    task automatic run(input logic [7:0] c1, input logic [9:0] av, input logic [9:0] pv);
        apb(1, 12'h020, 0);
        apb(1, 12'h008, 32'(av[7:0]));
        apb(1, 12'h00C, 32'(av[9:8]));
        apb(1, 12'h018, 32'(pv[7:0]));
        apb(1, 12'h01C, 32'(pv[9:8]));
        apb(1, 12'h024, 32'(c1));
        apb(1, 12'h020, 32'h8);
        // the enable edge reaches the pin one clock after the write lands
        @(posedge CLK);
        #1;
    endtask
    // cycles between two pulses, pin high cycles, pulses of the other kind
    task automatic meas(input logic per);
        g = 0;
        h = 0;
        o = 0;
        do begin
            @(posedge CLK);
            #1;
        end while ((per ? PER_MATCH : CMPA_MATCH) !== 1'b1);
        do begin
            @(posedge CLK);
            #1;
            g++;
            h += TMR_OUT;
            o += per ? CMPA_MATCH : PER_MATCH;
        end while ((per ? PER_MATCH : CMPA_MATCH) !== 1'b1);
    endtask
    task automatic final_report();
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        // reset values, then random data through the compare bytes
        for (int i = 0; i < 8; i++) begin
            apb(0, 12'(4 * i), 0);
            chk(rv, 0);
        end
        for (int i = 2; i < 8; i++) begin
            a = rnd();
            TICK <= a[31];
            apb(1, 12'(4 * i), a);
            apb(0, 12'(4 * i), 0);
            chk(rv, i[0] ? a & 32'h3 : a & 32'hFF);
        end
        apb(1, 12'h000, 32'hFF);
        apb(0, 12'h000, 0);
        chk(rv, 0);
        apb(0, 12'h030, 0);
        chk({sl, rv}, {1'b1, 32'h0});
        TICK <= 1'b1;
        // compare mode, toggle, period clear, then compare a clear with drive high
        run(8'h38, 10'd5, 10'd9);
        chk(TMR_OUT, 1);
        meas(1);
        chk({g, o}, {32'd9, 32'd1});
        run(8'h21, 10'd4, 10'd2);
        meas(0);
        chk({g, o, 31'h0, TMR_OUT}, {32'd4, 32'd0, 32'd1});
        run(8'h30, 10'd0, 10'd0);
        meas(1);
        chk({g, o}, {32'd1024, 32'd0});
        // stopped counter keeps its value
        apb(1, 12'h020, 0);
        apb(0, 12'h000, 0);
        p = rv;
        repeat (5) @(posedge CLK);
        apb(0, 12'h000, 0);
        chk(rv, p);
        // both flags stand from the runs above, write one clears them
        apb(0, 12'h028, 0);
        chk(rv, 3);
        apb(1, 12'h028, 32'h3);
        apb(0, 12'h028, 0);
        chk(rv, 0);
        run(8'hC8, 10'd3, 10'd7);
        meas(1);
        chk({g, 30'h0, TMR_OUT_OE, TMR_OUT}, {32'd7, 32'd0});
        // pwm: duty, full duty, inverted, forced inactive, forced active
        for (int i = 0; i < 5; i++) begin
            p = 3 + rnd() % 20;
            a = i == 1 ? p + 2 : 1 + rnd() % (p - 1);
            run(i == 2 ? 8'hAC : i == 3 ? 8'h88 : i == 4 ? 8'h98 : 8'hA9, 10'(a), 10'(p));
            meas(1);
            chk({g, o, 31'h0, TMR_OUT_OE}, {p, 32'(i != 1), 32'd1});
            chk(h, i == 1 || i == 4 ? p : i == 2 ? p - a : i == 3 ? 0 : a);
        end
        run(8'hA8, 10'd100, 10'd0);
        meas(1);
        chk({g, h}, {32'd1024, 32'd100});
        final_report();
    end
endmodule
bind ptmr_top ptmr_props u_props (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .TICK, .TMR_OUT, .TMR_OUT_OE, .CMPA_MATCH, .PER_MATCH);
`default_nettype wire
